//--- switch_global_control_regs.sv
// Summary of operation
// - Limit broadcast blocks; low threshold resets 0x63.
// - Period 67ms at 100M, 500ms at 10M.
// - Threshold joins upper three and low byte.
// - Power-save bit six drives PHY power save.
// - Bit one sets low LED select only.
// - High select from strap; low resets strap.
// - Three LED mappings; with high select set, low is ignored.
`timescale 1ns/1ns
`default_nettype none
module switch_global_control_regs
  import sgc_pkg::*;
#(
  parameter int NUM_PORTS     = 3,
  parameter int FAST_PERIOD   = PERIOD_FAST_CYC,
  parameter int SLOW_PERIOD   = PERIOD_SLOW_CYC
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic                   clkEn,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWdata,
  output logic [7:0]                  regRdata,
  output logic                        regHit,
  input  wire logic [2:0]             stormRateHigh,
  input  wire logic [NUM_PORTS-1:0]   stormEnable,
  input  wire logic                   led_select_low_strap,
  input  wire logic                   led_select_high_strap,
  input  wire logic [NUM_PORTS-1:0]   portLinkUp,
  input  wire logic [NUM_PORTS-1:0]   portActivity,
  input  wire logic [NUM_PORTS-1:0]   portFullDuplex,
  input  wire logic [NUM_PORTS-1:0]   portCollision,
  input  wire logic [NUM_PORTS-1:0]   portSpeed100,
  input  wire logic [NUM_PORTS-1:0]   rxBcast,
  input  wire logic [NUM_PORTS-1:0]   rxByte,
  input  wire logic [NUM_PORTS-1:0]   rxFrameEnd,
  output logic [NUM_PORTS-1:0]        dropBcast,
  output logic [NUM_PORTS-1:0]        port_indicator_0,
  output logic [NUM_PORTS-1:0]        port_indicator_1,
  output logic [NUM_PORTS-1:0]        port_indicator_2,
  output logic [NUM_PORTS-1:0]        port_indicator_3,
  output logic                        phyPowerSave,
  output logic                        special_tag_type_mode,
  output logic                        led_select_low,
  output logic                        led_select_high
);

  ////////////////////////////////////////////////////////////////////////////
  // Straps pass two flops; they are caught once after reset release.
  logic [1:0] strapMeta_reg, strapSync_reg;
  logic [1:0] strapCnt_reg,  strapCnt_next;

  logic [7:0] stormLow_reg,  stormLow_next;
  logic [7:0] testA_reg,     testA_next;
  logic [7:0] testB_reg,     testB_next;
  logic [7:0] testC_reg,     testC_next;
  logic [7:0] ctrl_reg,      ctrl_next;
  logic [7:0] rsvd_reg,      rsvd_next;
  logic [7:0] scr1_reg,      scr1_next;
  logic [7:0] scr2_reg,      scr2_next;
  logic [7:0] scr3_reg,      scr3_next;
  logic       ledHigh_reg,   ledHigh_next;
  logic [7:0] rdata_reg,     rdata_next;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strapMeta_reg <= 2'h0;
      strapSync_reg <= 2'h0;
    end else if (clkEn) begin
      strapMeta_reg <= {led_select_high_strap, led_select_low_strap};
      strapSync_reg <= strapMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  always_comb begin
    strapCnt_next = strapCnt_reg;
    stormLow_next = stormLow_reg;
    testA_next    = testA_reg;
    testB_next    = testB_reg;
    testC_next    = testC_reg;
    ctrl_next     = ctrl_reg;
    rsvd_next     = rsvd_reg;
    scr1_next     = scr1_reg;
    scr2_next     = scr2_reg;
    scr3_next     = scr3_reg;
    ledHigh_next  = ledHigh_reg;
    rdata_next    = rdata_reg;
    if (strapCnt_reg != 2'h3) begin
      strapCnt_next = strapCnt_reg + 2'h1;
      if (strapCnt_reg == 2'h2) begin
        ledHigh_next = strapSync_reg[1];
        ctrl_next[LED_SEL_LOW_BIT] = strapSync_reg[0];
      end
    end
    if (regWrite) begin
      if (hit(regAddr, STORM_RATE_LOW_OFS)) begin
        stormLow_next = regWdata;
      end else if (hit(regAddr, FACTORY_TEST_A_OFS)) begin
        testA_next = regWdata;
      end else if (hit(regAddr, FACTORY_TEST_B_OFS)) begin
        testB_next = regWdata;
      end else if (hit(regAddr, FACTORY_TEST_C_OFS)) begin
        testC_next = regWdata;
      end else if (hit(regAddr, POWER_LED_CTRL_OFS)) begin
        // Software sets low select.
        // Bit seven is read-only and stays zero.
        ctrl_next = {1'b0, regWdata[6:0]};
      end else if (hit(regAddr, SCRATCH_ONE_OFS)) begin
        scr1_next = regWdata;
      end else if (hit(regAddr, SCRATCH_TWO_OFS)) begin
        scr2_next = regWdata;
      end else if (hit(regAddr, SCRATCH_THREE_OFS)) begin
        scr3_next = regWdata;
      end
    end
    if (regRead) begin
      if (hit(regAddr, STORM_RATE_LOW_OFS)) begin
        rdata_next = stormLow_reg;
      end else if (hit(regAddr, FACTORY_TEST_A_OFS)) begin
        rdata_next = testA_reg;
      end else if (hit(regAddr, FACTORY_TEST_B_OFS)) begin
        rdata_next = testB_reg;
      end else if (hit(regAddr, FACTORY_TEST_C_OFS)) begin
        rdata_next = testC_reg;
      end else if (hit(regAddr, POWER_LED_CTRL_OFS)) begin
        rdata_next = ctrl_reg;
      end else if (hit(regAddr, RESERVED_BYTE_OFS)) begin
        rdata_next = rsvd_reg;
      end else if (hit(regAddr, SCRATCH_ONE_OFS)) begin
        rdata_next = scr1_reg;
      end else if (hit(regAddr, SCRATCH_TWO_OFS)) begin
        rdata_next = scr2_reg;
      end else if (hit(regAddr, SCRATCH_THREE_OFS)) begin
        rdata_next = scr3_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strapCnt_reg <= 2'h0;
      stormLow_reg <= STORM_RATE_LOW_RST;
      testA_reg    <= FACTORY_TEST_A_RST;
      testB_reg    <= FACTORY_TEST_B_RST;
      testC_reg    <= FACTORY_TEST_C_RST;
      ctrl_reg     <= POWER_LED_CTRL_RST;
      rsvd_reg     <= RESERVED_BYTE_RST;
      scr1_reg     <= SCRATCH_RST;
      scr2_reg     <= SCRATCH_RST;
      scr3_reg     <= SCRATCH_RST;
      ledHigh_reg  <= 1'b0;
      rdata_reg    <= 8'h00;
    end else if (clkEn) begin
      strapCnt_reg <= strapCnt_next;
      stormLow_reg <= stormLow_next;
      testA_reg    <= testA_next;
      testB_reg    <= testB_next;
      testC_reg    <= testC_next;
      ctrl_reg     <= ctrl_next;
      rsvd_reg     <= rsvd_next;
      scr1_reg     <= scr1_next;
      scr2_reg     <= scr2_next;
      scr3_reg     <= scr3_next;
      ledHigh_reg  <= ledHigh_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;
  assign regHit   = (regAddr >= STORM_RATE_LOW_OFS)
                 && (regAddr <= SCRATCH_THREE_OFS);

  assign phyPowerSave          = ctrl_reg[POWER_SAVE_BIT];
  assign special_tag_type_mode = ctrl_reg[TAG_MODE_BIT];
  assign led_select_low        = ctrl_reg[LED_SEL_LOW_BIT];
  assign led_select_high       = ledHigh_reg;

  logic [10:0] threshold;
  assign threshold = {stormRateHigh, stormLow_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Each port keeps its own period timer because its speed sets the length.
  // The timers are wide; a shared one would cost less but drift per speed.
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [31:0] tmr_reg, tmr_next;
      logic        tick;
      sgc_port_if  pif ();

      always_comb begin
        tick     = 1'b0;
        tmr_next = tmr_reg + 32'h1;
        if (tmr_reg >= 32'(portSpeed100[p] ? FAST_PERIOD - 1
                                           : SLOW_PERIOD - 1)) begin
          tick     = 1'b1;
          tmr_next = 32'h0;
        end
      end

      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          tmr_reg <= 32'h0;
        end else if (clkEn) begin
          tmr_reg <= tmr_next;
        end
      end

      assign pif.linkUp      = portLinkUp[p];
      assign pif.activity    = portActivity[p];
      assign pif.fullDuplex  = portFullDuplex[p];
      assign pif.collision   = portCollision[p];
      assign pif.speed100    = portSpeed100[p];
      assign pif.rxBcast     = rxBcast[p];
      assign pif.rxByte      = rxByte[p];
      assign pif.rxFrameEnd  = rxFrameEnd[p];
      assign pif.stormEnable = stormEnable[p];
      assign pif.threshold   = threshold;
      assign pif.periodTick  = tick;

      sgc_storm_meter u_meter (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .clkEn      (clkEn),
        .ledSelLow  (led_select_low),
        .ledSelHigh (led_select_high),
        .mp         (pif.meter),
        .lp         (pif.led)
      );

      assign dropBcast[p]        = pif.dropBcast;
      assign port_indicator_0[p] = pif.indicators[0];
      assign port_indicator_1[p] = pif.indicators[1];
      assign port_indicator_2[p] = pif.indicators[2];
      assign port_indicator_3[p] = pif.indicators[3];

      a_period_length: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        tmr_reg > 32'(SLOW_PERIOD - 1) |-> 1'b0)
        else $error("period timer overran its length");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  a_storm_reset: assert property (
    @(posedge ref_clk)
    $rose(rst_b) |-> stormLow_reg == STORM_RATE_LOW_RST)
    else $error("threshold low byte not at reset value");

  a_power_save: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    clkEn && regWrite && regAddr == POWER_LED_CTRL_OFS
    |=> phyPowerSave == $past(regWdata[POWER_SAVE_BIT]))
    else $error("power save did not follow write");

  a_led_low_write: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    clkEn && regWrite && regAddr == POWER_LED_CTRL_OFS
    |=> led_select_low == $past(regWdata[LED_SEL_LOW_BIT]))
    else $error("low LED select did not follow write");

  a_led_high_fixed: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    strapCnt_reg == 2'h3 |=> $stable(led_select_high))
    else $error("high LED select changed after capture");

  // The joined value is checked where it acts, at the drop decision.
  a_threshold_join: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    clkEn && stormEnable[0]
    && g_port[0].u_meter.blockCnt_next >= {stormRateHigh, stormLow_reg}
    |=> dropBcast[0])
    else $error("drop did not follow joined threshold");

  a_scratch_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !(regWrite && regAddr == SCRATCH_ONE_OFS) |=> $stable(scr1_reg))
    else $error("scratch byte changed without write");

  a_drop_needs_en: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    dropBcast[0] |-> $past(stormEnable[0]))
    else $error("drop without storm enable");

endmodule : switch_global_control_regs
`default_nettype wire

//--- sgc_pkg.sv
package sgc_pkg;

  localparam logic [7:0] STORM_RATE_LOW_OFS  = 8'h07;
  localparam logic [7:0] FACTORY_TEST_A_OFS  = 8'h08;
  localparam logic [7:0] FACTORY_TEST_B_OFS  = 8'h09;
  localparam logic [7:0] FACTORY_TEST_C_OFS  = 8'h0a;
  localparam logic [7:0] POWER_LED_CTRL_OFS  = 8'h0b;
  localparam logic [7:0] RESERVED_BYTE_OFS   = 8'h0c;
  localparam logic [7:0] SCRATCH_ONE_OFS     = 8'h0d;
  localparam logic [7:0] SCRATCH_TWO_OFS     = 8'h0e;
  localparam logic [7:0] SCRATCH_THREE_OFS   = 8'h0f;

  localparam logic [7:0] STORM_RATE_LOW_RST  = 8'h63;
  localparam logic [7:0] FACTORY_TEST_A_RST  = 8'h4e;
  localparam logic [7:0] FACTORY_TEST_B_RST  = 8'h24;
  localparam logic [7:0] FACTORY_TEST_C_RST  = 8'h24;
  localparam logic [7:0] POWER_LED_CTRL_RST  = 8'h08;
  localparam logic [7:0] RESERVED_BYTE_RST   = 8'h00;
  localparam logic [7:0] SCRATCH_RST         = 8'h00;

  localparam int POWER_SAVE_BIT   = 6;
  localparam int TEST_MODE_BIT    = 4;
  localparam int LED_SEL_LOW_BIT  = 1;
  localparam int TAG_MODE_BIT     = 0;

  localparam int BLOCK_BYTES      = 64;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int PERIOD_FAST_MS   = 67;
  localparam int PERIOD_SLOW_MS   = 500;
  localparam int PERIOD_FAST_CYC  = PERIOD_FAST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PERIOD_SLOW_CYC  = PERIOD_SLOW_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SGC_LED_LINK_ACT,
    SGC_LED_SPEED_SPLIT,
    SGC_LED_ALT_A,
    SGC_LED_ALT_B
  } sgc_led_mode_t;

endpackage : sgc_pkg

//--- sgc_port_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sgc_port_if;
  logic        linkUp;
  logic        activity;
  logic        fullDuplex;
  logic        collision;
  logic        speed100;
  logic        rxBcast;
  logic        rxByte;
  logic        rxFrameEnd;
  logic        stormEnable;
  logic [10:0] threshold;
  logic        periodTick;
  logic        dropBcast;
  logic [3:0]  indicators;
  modport meter (input rxBcast, rxByte, rxFrameEnd, stormEnable, threshold,
                 periodTick, output dropBcast);
  modport led (input linkUp, activity, fullDuplex, collision, speed100,
               output indicators);
  modport top (output linkUp, activity, fullDuplex, collision, speed100,
               rxBcast, rxByte, rxFrameEnd, stormEnable, threshold,
               periodTick, input dropBcast, indicators);
endinterface : sgc_port_if
`default_nettype wire

//--- sgc_storm_meter.sv
`timescale 1ns/1ns
`default_nettype none
module sgc_storm_meter
  import sgc_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst_b,
  input  wire logic  clkEn,
  input  wire logic  ledSelLow,
  input  wire logic  ledSelHigh,
  sgc_port_if.meter  mp,
  sgc_port_if.led    lp
);

  logic [5:0]  byteCnt_reg,  byteCnt_next;
  logic [10:0] blockCnt_reg, blockCnt_next;
  logic        drop_reg,     drop_next;
  logic [3:0]  ind_reg,      ind_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    byteCnt_next  = byteCnt_reg;
    blockCnt_next = blockCnt_reg;
    drop_next     = drop_reg;
    if (mp.periodTick) begin
      byteCnt_next  = 6'h00;
      blockCnt_next = 11'h000;
    end else if (mp.rxBcast && mp.rxByte) begin
      byteCnt_next = byteCnt_reg + 6'h01;
      if (byteCnt_reg == 6'(BLOCK_BYTES - 1) && blockCnt_reg != 11'h7ff) begin
        blockCnt_next = blockCnt_reg + 11'h001;
      end
    end
    drop_next = mp.stormEnable && (blockCnt_next >= mp.threshold);
    ind_next = 4'h0;
    case ({ledSelHigh, ledSelLow})
      2'b00: begin
        ind_next[2] = lp.linkUp & ~lp.activity;
        ind_next[1] = lp.fullDuplex | lp.collision;
        ind_next[0] = lp.speed100;
      end
      2'b01: begin
        ind_next[2] = lp.linkUp & lp.speed100 & ~lp.activity;
        ind_next[1] = lp.linkUp & ~lp.speed100 & ~lp.activity;
        ind_next[0] = lp.fullDuplex;
      end
      default: begin
        ind_next[3] = lp.activity;
        ind_next[2] = lp.linkUp;
        ind_next[1] = lp.fullDuplex | lp.collision;
        ind_next[0] = lp.speed100;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      byteCnt_reg  <= 6'h00;
      blockCnt_reg <= 11'h000;
      drop_reg     <= 1'b0;
      ind_reg      <= 4'h0;
    end else if (clkEn) begin
      byteCnt_reg  <= byteCnt_next;
      blockCnt_reg <= blockCnt_next;
      drop_reg     <= drop_next;
      ind_reg      <= ind_next;
    end
  end

  assign mp.dropBcast = drop_reg;
  assign lp.indicators = ind_reg;

  // Every period boundary must start a fresh count.
  a_block_count_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    clkEn && mp.periodTick |=> blockCnt_reg == 11'h000)
    else $error("block count not cleared at period boundary");

endmodule : sgc_storm_meter
`default_nettype wire

//--- tb_switch_global_control_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_switch_global_control_regs
  import sgc_pkg::*;
;
  // Short periods keep the run small; expectations use these values.
  localparam int FAST = 400;
  localparam int SLOW = 2800;

  logic       ref_clk;
  logic       rst_b;
  logic       clkEn;
  logic       regWrite;
  logic       regRead;
  logic       selLowStrap;
  logic       selHighStrap;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic       regHit;
  logic       phyPowerSave;
  logic       tagMode;
  logic       selLow;
  logic       selHigh;
  logic [2:0] stormRateHigh;
  logic [2:0] stormEnable;
  logic [2:0] linkUp;
  logic [2:0] activity;
  logic [2:0] fullDuplex;
  logic [2:0] collision;
  logic [2:0] speed100;
  logic [2:0] rxBcast;
  logic [2:0] rxByte;
  logic [2:0] dropBcast;
  logic [2:0] ind0;
  logic [2:0] ind1;
  logic [2:0] ind2;
  logic [2:0] ind3;
  int         n_fail;
  int         compares;
  int         waited;
  logic [7:0] rstAddr [9];
  logic [7:0] rstVal  [9];

  switch_global_control_regs #(
    .NUM_PORTS   (3),
    .FAST_PERIOD (FAST),
    .SLOW_PERIOD (SLOW)
  ) dut (
    .ref_clk               (ref_clk),
    .rst_b                 (rst_b),
    .clkEn                 (clkEn),
    .regWrite              (regWrite),
    .regRead               (regRead),
    .regAddr               (regAddr),
    .regWdata              (regWdata),
    .regRdata              (regRdata),
    .regHit                (regHit),
    .stormRateHigh         (stormRateHigh),
    .stormEnable           (stormEnable),
    .led_select_low_strap  (selLowStrap),
    .led_select_high_strap (selHighStrap),
    .portLinkUp            (linkUp),
    .portActivity          (activity),
    .portFullDuplex        (fullDuplex),
    .portCollision         (collision),
    .portSpeed100          (speed100),
    .rxBcast               (rxBcast),
    .rxByte                (rxByte),
    .rxFrameEnd            (3'h0),
    .dropBcast             (dropBcast),
    .port_indicator_0      (ind0),
    .port_indicator_1      (ind1),
    .port_indicator_2      (ind2),
    .port_indicator_3      (ind3),
    .phyPowerSave          (phyPowerSave),
    .special_tag_type_mode (tagMode),
    .led_select_low        (selLow),
    .led_select_high       (selHigh)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, hi);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    regWrite = 1'b1;
    regAddr  = addr;
    regWdata = data;
    @(negedge ref_clk);
    regWrite = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge ref_clk);
    regRead = 1'b1;
    regAddr = addr;
    @(negedge ref_clk);
    regRead = 1'b0;
    chk_reg(regRdata, exp);
  endtask

  // Bytes arrive back to back on all ports, the densest legal load.
  task automatic send_bytes(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      rxBcast = 3'h7;
      rxByte  = 3'h7;
    end
    @(negedge ref_clk);
    rxByte  = 3'h0;
    rxBcast = 3'h0;
  endtask

  // The period counter is free running, so tests first align to a boundary.
  task automatic wait_clear();
    waited = 0;
    while (dropBcast[0] !== 1'b0 && waited < 4000) begin
      @(negedge ref_clk);
      waited++;
    end
  endtask

  task automatic send_until_drop();
    for (int i = 0; i < 600 && dropBcast[0] !== 1'b1; i++) begin
      send_bytes(1);
    end
  endtask

  task automatic led_case(input logic [2:0] spd, input logic [2:0] dpx,
                          input logic [2:0] e2, input logic [2:0] e1,
                          input logic [2:0] e0);
    @(negedge ref_clk);
    speed100   = spd;
    fullDuplex = dpx;
    repeat (3) @(negedge ref_clk);
    chk_pin(ind2, e2);
    chk_pin(ind1, e1);
    chk_pin(ind0, e0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    rst_b         = 1'b0;
    clkEn         = 1'b1;
    regWrite      = 1'b0;
    regRead       = 1'b0;
    regAddr       = 8'h00;
    regWdata      = 8'h00;
    selLowStrap   = 1'b1;
    selHighStrap  = 1'b0;
    stormRateHigh = 3'h0;
    stormEnable   = 3'h3;
    linkUp        = 3'h7;
    activity      = 3'h0;
    fullDuplex    = 3'h7;
    collision     = 3'h0;
    speed100      = 3'h7;
    rxBcast       = 3'h0;
    rxByte        = 3'h0;
    n_fail        = 0;
    compares      = 0;
    waited        = 0;
    rstAddr = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
    rstVal  = '{8'h63, 8'h4e, 8'h24, 8'h24, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      reg_read(rstAddr[i], rstVal[i]);
    end
    chk_pin({2'h0, regHit}, 3'h1);
    chk_pin({2'h0, selLow}, 3'h1);
    chk_pin({2'h0, selHigh}, 3'h0);
    reg_write(8'h0d, 8'ha5);
    reg_write(8'h0e, 8'h5a);
    reg_write(8'h0f, 8'hc3);
    reg_write(8'h0c, 8'hff);
    // A write while the enable is low must leave every register untouched.
    clkEn = 1'b0;
    reg_write(8'h0d, 8'h3c);
    clkEn = 1'b1;
    reg_read(8'h0d, 8'ha5);
    reg_read(8'h0e, 8'h5a);
    reg_read(8'h0f, 8'hc3);
    reg_read(8'h0c, 8'h00);
    reg_read(8'h10, 8'h00);
    chk_pin({2'h0, regHit}, 3'h0);
    // Bit four stays clear: setting it would enter an unsupported test mode.
    reg_write(8'h0b, 8'hcb);
    reg_read(8'h0b, 8'h4b);
    chk_pin({phyPowerSave, selLow, tagMode}, 3'h7);
    chk_pin({2'h0, selHigh}, 3'h0);
    reg_write(8'h0b, 8'h08);
    chk_pin({phyPowerSave, selLow, tagMode}, 3'h0);
    led_case(3'h7, 3'h7, 3'h7, 3'h7, 3'h7);
    led_case(3'h0, 3'h0, 3'h7, 3'h0, 3'h0);
    activity  = 3'h7;
    collision = 3'h7;
    led_case(3'h7, 3'h0, 3'h0, 3'h7, 3'h7);
    activity  = 3'h0;
    collision = 3'h0;
    reg_write(8'h0b, 8'h0a);
    led_case(3'h7, 3'h0, 3'h7, 3'h0, 3'h0);
    led_case(3'h0, 3'h7, 3'h0, 3'h7, 3'h7);
    chk_pin(ind3, 3'h0);
    @(negedge ref_clk);
    speed100 = 3'h7;
    reg_write(8'h07, 8'h02);
    send_until_drop();
    wait_clear();
    send_bytes(64);
    chk_pin(dropBcast, 3'h0);
    send_bytes(64);
    repeat (2) @(negedge ref_clk);
    chk_pin(dropBcast, 3'h3);
    wait_clear();
    chk_span(waited, 1, FAST);
    speed100 = 3'h0;
    send_until_drop();
    wait_clear();
    send_bytes(128);
    wait_clear();
    chk_span(waited, FAST + 1, SLOW);
    stormRateHigh = 3'h1;
    send_bytes(192);
    repeat (2) @(negedge ref_clk);
    chk_pin(dropBcast, 3'h0);
    stormRateHigh = 3'h0;
    repeat (3) @(negedge ref_clk);
    chk_pin(dropBcast, 3'h3);
    // A second reset with the other strap levels selects the last mapping.
    selLowStrap  = 1'b0;
    selHighStrap = 1'b1;
    rst_b        = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk_pin({1'b0, selHigh, selLow}, 3'h2);
    reg_read(8'h07, 8'h63);
    reg_read(8'h0b, 8'h08);
    reg_read(8'h0d, 8'h00);
    activity  = 3'h5;
    collision = 3'h2;
    led_case(3'h6, 3'h0, 3'h7, 3'h2, 3'h6);
    chk_pin(ind3, 3'h5);
    report_and_stop();
  end
endmodule // tb_switch_global_control_regs
`default_nettype wire
